// ==== test_vie_encoder.sv ====
// testbench for the vector encoder
`timescale 1ns/1ps
module test_vie_encoder;
    logic        clk_in = 1'b0, arst_n_in = 1'b0, serve = 1'b0, wen = 1'b0, kick = 1'b1;
    logic [21:0] set = 22'h0, src;
    logic        clr, pend, crst, expd;
    logic [7:0]  vec;
    int          fail_count = 0, check_count = 0;
    logic [7:0]  code [22] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30, 8'h32, 8'h38,
        8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h60, 8'h62, 8'h80, 8'h84};
    always #2.5 clk_in = ~clk_in;
    vie_encoder #(.WDT_TIMEOUT_CYC(50)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .irq_src_in(src), .vec_clear_in(clr), .wdt_enable_in(wen), .wdt_kick_in(kick),
        .interrupt_vector_register_out(vec), .irq_pending_out(pend),
        .core_reset_out(crst), .wdt_expired_out(expd));
    vie_fw_model fw (.clk_in(clk_in), .arst_n_in(arst_n_in), .set_in(set), .serve_in(serve),
        .pending_in(pend), .src_out(src), .clr_out(clr));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic raise(input logic [21:0] b);
        set = b;
        step(1);
        set = 22'h0;
        step(4);
    endtask
    task automatic t_each;
        for (int i = 0; i < 22; i++) begin
            raise(22'h1 << i);
            chk(vec, code[i]);
            chk({7'h0, pend}, 8'h01);
            serve = 1'b1;
            step(7);
            chk(vec, 8'h00);
            chk({7'h0, pend}, 8'h00);
            serve = 1'b0;
        end
    endtask
    task automatic t_prio;
        raise(22'h000001);
        chk(vec, 8'h12);
        raise(22'h200000);
        chk(vec, 8'h84);
        serve = 1'b1;
        step(7);
        chk(vec, 8'h12);
        step(6);
        serve = 1'b0;
        chk(vec, 8'h00);
    endtask
    task automatic t_wdt;
        step(8);
        kick = 1'b0;
        raise(22'h1);
        step(56);
        chk({6'h0, crst, expd}, 8'h03);
        chk(vec, 8'h00);
        wen = 1'b1;
        kick = 1'b1;
        step(24);
        chk({6'h0, crst, expd}, 8'h01);
        chk(vec, 8'h12);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        step(4);
        arst_n_in = 1'b1;
        step(1);
        chk(vec, 8'h00);
        t_each;
        t_prio;
        t_wdt;
        summarize;
    end
    initial begin
        step(3000);
        fail_count++;
        summarize;
    end
endmodule

// ==== vie_defs.vh ====
// constants for the vectored interrupt encoder
// Contract
// (RULE1) larger pending vector code wins arbitration
// (RULE2) vector is group[7:4], index[3:1], bit0 zero
// (RULE3) zero means none; endpoints 1-3 in groups 1,2
// (RULE4) group 3 carries the USB bus events
// (RULE5) group 4: I2C pair, endpoint 0 in/out
// (RULE6) UART groups 5,6; DMA 1,3 group 8
// (RULE7) firmware clears owner status for events, UART, DMA
// (RULE8) firmware stays disconnected 200 ms before reset
// (RULE9) watchdog enabled straight out of reset
// (RULE10) firmware forces reset by starving the watchdog
// (RULE11) watchdog expiry gives power-on-equivalent reset
// (RULE12) handler clears source before clearing vector
// (RULE13) after clear, reload highest pending or zero
`ifndef VIE_DEFS_VH
`define VIE_DEFS_VH
`define VIE_NUM_SRC          22
`define VIE_VEC_NONE         8'h00
`define VIE_SRC_OEP1         0
`define VIE_SRC_OEP2         1
`define VIE_SRC_OEP3         2
`define VIE_SRC_IEP1         3
`define VIE_SRC_IEP2         4
`define VIE_SRC_IEP3         5
`define VIE_SRC_SETUP_OVW    6
`define VIE_SRC_SETUP        7
`define VIE_SRC_RESUME       8
`define VIE_SRC_SUSPEND      9
`define VIE_SRC_BUS_RESET    10
`define VIE_SRC_WAKEUP       11
`define VIE_SRC_I2C_A        12
`define VIE_SRC_I2C_B        13
`define VIE_SRC_IEP0         14
`define VIE_SRC_OEP0         15
`define VIE_SRC_UART_STAT    16
`define VIE_SRC_UART_MODEM   17
`define VIE_SRC_RXF          18
`define VIE_SRC_TXE          19
`define VIE_SRC_DMA1         20
`define VIE_SRC_DMA3         21
`define VIE_WDT_TIMEOUT_CYC  32'd1000000
`define VIE_RST_PULSE_CYC    8'h10
`define VIE_WDT_EN_RST       1'b1
`endif

// ==== vie_encoder.v ====
// vectored interrupt encoder with firmware-forced watchdog reset
`timescale 1ns/1ps
`include "vie_defs.vh"
module vie_encoder #(
    parameter WDT_TIMEOUT_CYC = `VIE_WDT_TIMEOUT_CYC
) (
    input  wire        clk_in,
    input  wire        arst_n_in,
    input  wire [21:0] irq_src_in,
    input  wire        vec_clear_in,
    input  wire        wdt_enable_in,
    input  wire        wdt_kick_in,
    output wire [7:0]  interrupt_vector_register_out,
    output wire        irq_pending_out,
    output wire        core_reset_out,
    output wire        wdt_expired_out
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_SHOW  = 3'b010;
    localparam ST_RESET = 3'b100;

    reg  [7:0]  vec_ff;
    reg  [7:0]  nxt_vec;
    reg  [21:0] src_s1_ff;
    reg  [21:0] src_s2_ff;
    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg  [7:0]  top_code;
    wire [3:0]  top_group;
    wire [2:0]  top_index;
    wire [7:0]  top_vec;
    wire        wdt_rst;

    // group and index packed into the vector layout, bit 0 low
    function [7:0] vie_pack;
        input [3:0] grp;
        input [2:0] idx;
        begin
            vie_pack = {grp, idx, 1'b0}; // RULE2
        end
    endfunction

    // group field of a source; unknown sources give group 0
    function [3:0] vie_group;
        input integer s;
        begin
            case (s)
                `VIE_SRC_OEP1:       vie_group = 4'h1; // RULE3
                `VIE_SRC_OEP2:       vie_group = 4'h1;
                `VIE_SRC_OEP3:       vie_group = 4'h1;
                `VIE_SRC_IEP1:       vie_group = 4'h2;
                `VIE_SRC_IEP2:       vie_group = 4'h2;
                `VIE_SRC_IEP3:       vie_group = 4'h2;
                `VIE_SRC_SETUP_OVW:  vie_group = 4'h3; // RULE4
                `VIE_SRC_SETUP:      vie_group = 4'h3;
                `VIE_SRC_RESUME:     vie_group = 4'h3;
                `VIE_SRC_SUSPEND:    vie_group = 4'h3;
                `VIE_SRC_BUS_RESET:  vie_group = 4'h3;
                `VIE_SRC_WAKEUP:     vie_group = 4'h3;
                `VIE_SRC_I2C_A:      vie_group = 4'h4; // RULE5
                `VIE_SRC_I2C_B:      vie_group = 4'h4;
                `VIE_SRC_IEP0:       vie_group = 4'h4;
                `VIE_SRC_OEP0:       vie_group = 4'h4;
                `VIE_SRC_UART_STAT:  vie_group = 4'h5; // RULE6
                `VIE_SRC_UART_MODEM: vie_group = 4'h5;
                `VIE_SRC_RXF:        vie_group = 4'h6;
                `VIE_SRC_TXE:        vie_group = 4'h6;
                `VIE_SRC_DMA1:       vie_group = 4'h8;
                `VIE_SRC_DMA3:       vie_group = 4'h8;
                default:             vie_group = 4'h0;
            endcase
        end
    endfunction

    // index field of a source inside its group
    function [2:0] vie_index;
        input integer s;
        begin
            case (s)
                `VIE_SRC_OEP1:       vie_index = 3'h1; // RULE3
                `VIE_SRC_OEP2:       vie_index = 3'h2;
                `VIE_SRC_OEP3:       vie_index = 3'h3;
                `VIE_SRC_IEP1:       vie_index = 3'h1;
                `VIE_SRC_IEP2:       vie_index = 3'h2;
                `VIE_SRC_IEP3:       vie_index = 3'h3;
                `VIE_SRC_SETUP_OVW:  vie_index = 3'h0; // RULE4
                `VIE_SRC_SETUP:      vie_index = 3'h1;
                `VIE_SRC_RESUME:     vie_index = 3'h4;
                `VIE_SRC_SUSPEND:    vie_index = 3'h5;
                `VIE_SRC_BUS_RESET:  vie_index = 3'h6;
                `VIE_SRC_WAKEUP:     vie_index = 3'h7;
                `VIE_SRC_I2C_A:      vie_index = 3'h0; // RULE5
                `VIE_SRC_I2C_B:      vie_index = 3'h1;
                `VIE_SRC_IEP0:       vie_index = 3'h2;
                `VIE_SRC_OEP0:       vie_index = 3'h3;
                `VIE_SRC_UART_STAT:  vie_index = 3'h0; // RULE6
                `VIE_SRC_UART_MODEM: vie_index = 3'h1;
                `VIE_SRC_RXF:        vie_index = 3'h0;
                `VIE_SRC_TXE:        vie_index = 3'h1;
                `VIE_SRC_DMA1:       vie_index = 3'h0;
                `VIE_SRC_DMA3:       vie_index = 3'h2;
                default:             vie_index = 3'h0;
            endcase
        end
    endfunction

    // full vector code of a source
    function [7:0] vie_code;
        input integer s;
        begin
            vie_code = vie_pack(vie_group(s), vie_index(s)); // RULE2
        end
    endfunction

    // arbitration compare: the larger code wins
    function vie_wins;
        input [7:0] cand;
        input [7:0] held;
        begin
            vie_wins = (cand > held); // RULE1
        end
    endfunction

    // guard so a reserved code can never reach the vector
    function vie_legal;
        input [7:0] code;
        begin
            case (code)
                8'h12:   vie_legal = 1'b1; // RULE3
                8'h14:   vie_legal = 1'b1;
                8'h16:   vie_legal = 1'b1;
                8'h22:   vie_legal = 1'b1;
                8'h24:   vie_legal = 1'b1;
                8'h26:   vie_legal = 1'b1;
                8'h30:   vie_legal = 1'b1; // RULE4
                8'h32:   vie_legal = 1'b1;
                8'h38:   vie_legal = 1'b1;
                8'h3A:   vie_legal = 1'b1;
                8'h3C:   vie_legal = 1'b1;
                8'h3E:   vie_legal = 1'b1;
                8'h40:   vie_legal = 1'b1; // RULE5
                8'h42:   vie_legal = 1'b1;
                8'h44:   vie_legal = 1'b1;
                8'h46:   vie_legal = 1'b1;
                8'h50:   vie_legal = 1'b1; // RULE6
                8'h52:   vie_legal = 1'b1;
                8'h60:   vie_legal = 1'b1;
                8'h62:   vie_legal = 1'b1;
                8'h80:   vie_legal = 1'b1;
                8'h84:   vie_legal = 1'b1;
                default: vie_legal = 1'b0;
            endcase
        end
    endfunction

    // scan every source; the largest legal pending code survives
    integer i;
    always @* begin
        top_code = `VIE_VEC_NONE; // RULE3
        for (i = 0; i < `VIE_NUM_SRC; i = i + 1) begin
            if (src_s2_ff[i] && vie_legal(vie_code(i)) && vie_wins(vie_code(i), top_code)) begin
                top_code = vie_code(i); // RULE1
            end
        end
    end

    assign top_group = top_code[7:4];
    assign top_index = top_code[3:1];
    assign top_vec   = vie_pack(top_group, top_index); // RULE2

    // one-hot vector state: empty, showing a code, held in watchdog reset
    always @* begin
        nxt_state = state_ff;
        nxt_vec   = vec_ff;
        case (state_ff)
            ST_IDLE: begin
                if (vec_clear_in) begin
                    nxt_vec = `VIE_VEC_NONE;
                end else if (top_vec != `VIE_VEC_NONE) begin
                    nxt_state = ST_SHOW;
                    nxt_vec   = top_vec; // RULE13
                end
            end
            ST_SHOW: begin
                if (vec_clear_in) begin
                    // reload waits a cycle; RULE12 expects the source gone
                    nxt_state = ST_IDLE;
                    nxt_vec   = `VIE_VEC_NONE; // RULE13
                end else if (vie_wins(top_vec, vec_ff)) begin
                    nxt_vec = top_vec; // RULE1
                end
            end
            ST_RESET: begin
                nxt_state = ST_IDLE;
                nxt_vec   = `VIE_VEC_NONE;
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_vec   = `VIE_VEC_NONE;
            end
        endcase
        if (wdt_rst) begin
            nxt_state = ST_RESET; // RULE11
            nxt_vec   = `VIE_VEC_NONE;
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            src_s1_ff <= 22'h0;
            src_s2_ff <= 22'h0;
        end else if (wdt_rst) begin
            // RULE11
            src_s1_ff <= 22'h0;
            src_s2_ff <= 22'h0;
        end else begin
            src_s1_ff <= irq_src_in;
            src_s2_ff <= src_s1_ff;
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= ST_IDLE;
            vec_ff   <= `VIE_VEC_NONE;
        end else begin
            state_ff <= nxt_state;
            vec_ff   <= nxt_vec;
        end
    end

    vie_wdt #(
        .TIMEOUT_CYC (WDT_TIMEOUT_CYC)
    ) u_wdt (
        .clk_in          (clk_in),
        .arst_n_in       (arst_n_in),
        .wdt_enable_in   (wdt_enable_in), // RULE10
        .wdt_kick_in     (wdt_kick_in),
        .wdt_reset_out   (wdt_rst),
        .wdt_expired_out (wdt_expired_out)
    );

    assign interrupt_vector_register_out = vec_ff;
    assign irq_pending_out               = state_ff[1]; // one-hot show bit
    assign core_reset_out                = wdt_rst | ~arst_n_in; // RULE11
endmodule

// ==== vie_encoder_props.sv ====
// checker for the vector encoder
`timescale 1ns/1ps
module vie_encoder_props (
    input wire logic       clk_in,
    input wire logic       arst_n_in,
    input wire logic       vec_clear_in,
    input wire logic [7:0] interrupt_vector_register_out,
    input wire logic       irq_pending_out,
    input wire logic       core_reset_out
);
    wire [7:0] v = interrupt_vector_register_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    property p_b0; v[0] == 1'b0; endproperty
    a_b0: assert property (p_b0) else $error("bit0 set");
    property p_pd; irq_pending_out == (v != 8'h00); endproperty
    a_pd: assert property (p_pd) else $error("pending bad");
    property p_ep; v[7:5] == 3'h0 && v[4] || v[7:4] == 4'h2 |-> !v[3] && v[2:1] != 2'h0; endproperty
    a_ep: assert property (p_ep) else $error("endpoint code");
    property p_g3; v[7:4] == 4'h3 |-> v[3:2] != 2'h1; endproperty
    a_g3: assert property (p_g3) else $error("group3 code");
    property p_g4; v[7:4] == 4'h4 |-> !v[3]; endproperty
    a_g4: assert property (p_g4) else $error("group4 code");
    property p_hi; v[7:4] > 4'h4 |-> v inside {8'h50, 8'h52, 8'h60, 8'h62, 8'h80, 8'h84}; endproperty
    a_hi: assert property (p_hi) else $error("upper code");
    property p_cl; vec_clear_in |=> v == 8'h00; endproperty
    a_cl: assert property (p_cl) else $error("clear ignored");
    property p_pr; !vec_clear_in && !core_reset_out |=> core_reset_out || v >= $past(v); endproperty
    a_pr: assert property (p_pr) else $error("lower code won");
    property p_wd; $rose(core_reset_out) |=> (core_reset_out && v == 8'h00)[*8]; endproperty
    a_wd: assert property (p_wd) else $error("reset pulse");
endmodule
bind vie_encoder vie_encoder_props u_props (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .vec_clear_in(vec_clear_in), .interrupt_vector_register_out(interrupt_vector_register_out),
    .irq_pending_out(irq_pending_out), .core_reset_out(core_reset_out));

// ==== vie_fw_model.sv ====
// firmware model: drops top source, then clears vector
`timescale 1ns/1ps
module vie_fw_model (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic [21:0] set_in,
    input  wire logic        serve_in,
    input  wire logic        pending_in,
    output wire logic [21:0] src_out,
    output wire logic        clr_out
);
    logic [21:0] src_ff, m;
    logic [2:0]  wait_ff;
    logic        clr_ff;
    wire         go = serve_in && pending_in && wait_ff == 3'h0;
    assign src_out = src_ff;
    assign clr_out = clr_ff;
    always @* begin
        m = 22'h0;
        for (int i = 0; i < 22; i++) if (src_ff[i]) m = 22'h1 << i;
    end
    // clear waits out the input synchroniser
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            src_ff  <= 22'h0;
            wait_ff <= 3'h0;
            clr_ff  <= 1'b0;
        end else begin
            src_ff  <= (src_ff | set_in) & ~(go ? m : 22'h0);
            wait_ff <= go ? 3'h5 : (wait_ff != 3'h0) ? wait_ff - 3'h1 : 3'h0;
            clr_ff  <= wait_ff == 3'h3;
        end
    end
endmodule

// ==== vie_wdt.v ====
// watchdog timer with power-on-equivalent reset output
`timescale 1ns/1ps
`include "vie_defs.vh"
module vie_wdt #(
    parameter TIMEOUT_CYC = `VIE_WDT_TIMEOUT_CYC
) (
    input  wire clk_in,
    input  wire arst_n_in,
    input  wire wdt_enable_in,
    input  wire wdt_kick_in,
    output wire wdt_reset_out,
    output wire wdt_expired_out
);
    reg [31:0] cnt_ff;
    reg [7:0]  pulse_ff;
    reg        en_ff;
    reg        exp_ff;
    wire       hit = en_ff && (cnt_ff >= TIMEOUT_CYC - 1);

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_ff    <= `VIE_WDT_EN_RST; // RULE9
            cnt_ff   <= 32'h0;
            pulse_ff <= 8'h00;
            exp_ff   <= 1'b0;
        end else if (pulse_ff != 8'h00) begin
            // hold enable and count at reset values while the pulse runs; exp_ff keeps its value
            pulse_ff <= pulse_ff - 8'h01;
            en_ff    <= `VIE_WDT_EN_RST;
            cnt_ff   <= 32'h0;
        end else begin
            en_ff <= en_ff | wdt_enable_in;
            if (wdt_kick_in || !en_ff) begin
                cnt_ff <= 32'h0;
            end else if (hit) begin
                cnt_ff   <= 32'h0;
                pulse_ff <= `VIE_RST_PULSE_CYC; // RULE11
                exp_ff   <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 32'h1;
            end
        end
    end

    assign wdt_reset_out   = (pulse_ff != 8'h00); // RULE11
    assign wdt_expired_out = exp_ff;
endmodule
